// [vpc_pkg.sv]
package vpc_pkg;
   // Register addresses on the plain register port
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_SYNTH = 4'h1;
   localparam logic [3:0] ADDR_EXT = 4'h2;
   localparam logic [3:0] ADDR_PAL_INDEX = 4'h3;
   localparam logic [3:0] ADDR_PAL_DATA = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h5;
   // Video control register fields
   localparam int CTRL_DIV_LSB = 0;
   localparam int CTRL_SRC_LSB = 3;
   localparam int CTRL_PRELOAD_LSB = 8;
   localparam int CTRL_BPP_LSB = 12;
   localparam int CTRL_HIRES_BIT = 16;
   localparam int CTRL_LCD_BIT = 17;
   // Synthesizer register fields
   localparam int SYNTH_R_LSB = 0;
   localparam int SYNTH_V_LSB = 8;
   localparam int MODULUS_W = 6;
   // Palette data word fields
   localparam int PAL_RED_LSB = 0;
   localparam int PAL_GREEN_LSB = 8;
   localparam int PAL_BLUE_LSB = 16;
   localparam int PAL_EXT_LSB = 24;
   // Reset values
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] SYNTH_RESET = 32'h0000_0202;
   localparam logic [7:0] EXT_RESET = 8'h00;
   // Preload granularity in words
   localparam logic [5:0] PRELOAD_STEP = 6'h04;
   localparam int IO_REF_FREQ_MHZ = 32;
   localparam int CLK_PERIOD_NS = 100;
   typedef enum logic [2:0] {BPP1, BPP2, BPP4, BPP8, BPP16, BPP32} vpc_bpp_e;
   typedef enum logic [1:0] {SRC_VCO, SRC_HIGH_FREQ, SRC_IO_REF} vpc_src_e;
endpackage

// [vpc_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module vpc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4,
   parameter int LW = $clog2(DEPTH + 1)
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [LW-1:0] level
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
   logic [LW-1:0] level_reg, level_next;
   logic push, pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign level_next = level_reg + LW'(push) - LW'(pop);
   assign out_data = mem_reg[rd_ptr_reg];
   assign level = level_reg;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         level_reg <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else if (flush) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         level_reg <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         level_reg <= level_next;
         in_ready <= level_next != LW'(DEPTH);
         out_valid <= level_next != '0;
      end
   end
endmodule
`default_nettype wire

// [vpc_pixel_path.sv]
// The address map and strobed register access were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module vpc_pixel_path #(
   parameter int VFIFO_DEPTH = 32
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic io_reference_clock,
   input wire logic vco_clock_in,
   input wire logic high_freq_clock_in,
   output logic vco_clock_inverted_out,
   output logic phase_compare_out,
   output logic phase_compare_oe,
   output logic phase_compare_mid,
   output logic pixel_clock_tick,
   input wire logic [31:0] video_word_data,
   input wire logic video_word_valid,
   output logic video_word_ready,
   input wire logic flyback,
   output logic video_dma_request,
   output logic [7:0] dac_red,
   output logic [7:0] dac_green,
   output logic [7:0] dac_blue,
   output logic pixel_out_valid,
   output logic [7:0] extension_output_port
);
   localparam int LW = $clog2(VFIFO_DEPTH + 1);

   logic [31:0] video_control_register;
   logic [31:0] synth_reg;
   logic [7:0] ext_reg;
   logic [7:0] pal_index_reg;
   logic [7:0] red_lut [256];
   logic [7:0] green_lut [256];
   logic [7:0] blue_lut [256];
   logic [3:0] ext_lut [16];

   // Register port
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         video_control_register <= vpc_pkg::CTRL_RESET;
         synth_reg <= vpc_pkg::SYNTH_RESET;
         ext_reg <= vpc_pkg::EXT_RESET;
         pal_index_reg <= 8'h00;
      end else if (reg_write) begin
         unique case (reg_addr)
            vpc_pkg::ADDR_CTRL: video_control_register <= reg_wdata;
            vpc_pkg::ADDR_SYNTH: synth_reg <= reg_wdata;
            vpc_pkg::ADDR_EXT: ext_reg <= reg_wdata[7:0];
            vpc_pkg::ADDR_PAL_INDEX: pal_index_reg <= reg_wdata[7:0];
            vpc_pkg::ADDR_PAL_DATA: pal_index_reg <= pal_index_reg + 8'h01;
            default: ;
         endcase
      end
   end

   // Palette storage, written through the auto-incrementing index
   always_ff @(posedge clk) begin
      if (reg_write && reg_addr == vpc_pkg::ADDR_PAL_DATA) begin
         red_lut[pal_index_reg] <= reg_wdata[vpc_pkg::PAL_RED_LSB +: 8];
         green_lut[pal_index_reg] <= reg_wdata[vpc_pkg::PAL_GREEN_LSB +: 8];
         blue_lut[pal_index_reg] <= reg_wdata[vpc_pkg::PAL_BLUE_LSB +: 8];
         if (pal_index_reg[7:4] == 4'h0) begin
            ext_lut[pal_index_reg[3:0]] <= reg_wdata[vpc_pkg::PAL_EXT_LSB +: 4];
         end
      end
   end

   // Sampled source clocks and their rising edges
   logic ref_d_reg, vco_d_reg, hf_d_reg;
   logic ref_rise, vco_rise, hf_rise;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ref_d_reg <= 1'b0;
         vco_d_reg <= 1'b0;
         hf_d_reg <= 1'b0;
         vco_clock_inverted_out <= 1'b1;
      end else begin
         ref_d_reg <= io_reference_clock;
         vco_d_reg <= vco_clock_in;
         hf_d_reg <= high_freq_clock_in;
         vco_clock_inverted_out <= ~vco_clock_in;
      end
   end
   assign ref_rise = io_reference_clock && !ref_d_reg;
   assign vco_rise = vco_clock_in && !vco_d_reg;
   assign hf_rise = high_freq_clock_in && !hf_d_reg;

   // Pixel clock source select and prescaler
   logic [1:0] src_sel;
   logic [2:0] div_sel, div_cnt_reg;
   logic src_rise;
   assign src_sel = video_control_register[vpc_pkg::CTRL_SRC_LSB +: 2];
   assign div_sel = video_control_register[vpc_pkg::CTRL_DIV_LSB +: 3];
   always_comb begin
      unique case (src_sel)
         vpc_pkg::SRC_VCO: src_rise = vco_rise;
         vpc_pkg::SRC_HIGH_FREQ: src_rise = hf_rise;
         vpc_pkg::SRC_IO_REF: src_rise = ref_rise;
         default: src_rise = 1'b0;
      endcase
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt_reg <= 3'h0;
         pixel_clock_tick <= 1'b0;
      end else begin
         pixel_clock_tick <= src_rise && div_cnt_reg >= div_sel;
         if (src_rise) begin
            div_cnt_reg <= (div_cnt_reg >= div_sel) ? 3'h0 : div_cnt_reg + 3'h1;
         end
      end
   end

   // Synthesizer dividers, modulus 0 behaves as 1
   logic [5:0] r_mod, v_mod, r_cnt_reg, v_cnt_reg;
   logic ref_div, vco_div;
   assign r_mod = synth_reg[vpc_pkg::SYNTH_R_LSB +: vpc_pkg::MODULUS_W];
   assign v_mod = synth_reg[vpc_pkg::SYNTH_V_LSB +: vpc_pkg::MODULUS_W];
   assign ref_div = ref_rise && (r_cnt_reg + 6'h01 >= r_mod);
   assign vco_div = vco_rise && (v_cnt_reg + 6'h01 >= v_mod);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r_cnt_reg <= 6'h00;
         v_cnt_reg <= 6'h00;
      end else begin
         if (ref_rise) begin
            r_cnt_reg <= ref_div ? 6'h00 : r_cnt_reg + 6'h01;
         end
         if (vco_rise) begin
            v_cnt_reg <= vco_div ? 6'h00 : v_cnt_reg + 6'h01;
         end
      end
   end

   // Phase-frequency comparator
   logic up_reg, down_reg, up_set, down_set, coincide;
   assign up_set = up_reg || ref_div;
   assign down_set = down_reg || vco_div;
   assign coincide = up_set && down_set;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         up_reg <= 1'b0;
         down_reg <= 1'b0;
         phase_compare_out <= 1'b0;
         phase_compare_oe <= 1'b0;
         phase_compare_mid <= 1'b0;
      end else begin
         up_reg <= up_set && !coincide;
         down_reg <= down_set && !coincide;
         phase_compare_out <= up_set && !down_set;
         phase_compare_oe <= up_set != down_set || coincide;
         phase_compare_mid <= coincide;
      end
   end

   // Video FIFO and refill request
   logic fifo_valid, fifo_pop;
   logic [31:0] fifo_word;
   logic [LW-1:0] fifo_level;
   logic [5:0] preload_words;
   vpc_fifo #(.WIDTH(32), .DEPTH(VFIFO_DEPTH)) u_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .flush(flyback),
      .in_valid(video_word_valid),
      .in_ready(video_word_ready),
      .in_data(video_word_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_word),
      .level(fifo_level)
   );
   assign preload_words =
      video_control_register[vpc_pkg::CTRL_PRELOAD_LSB +: 3] * vpc_pkg::PRELOAD_STEP;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         video_dma_request <= 1'b0;
      end else begin
         video_dma_request <= !flyback && LW'(preload_words) > fifo_level;
      end
   end

   // Pixel extraction from the head word
   vpc_pkg::vpc_bpp_e bpp;
   logic [4:0] pix_pos_reg, last_pos;
   logic [31:0] shifted;
   logic [7:0] pix, idx_r, idx_g, idx_b;
   logic [3:0] idx_e;
   assign bpp = vpc_pkg::vpc_bpp_e'(video_control_register[vpc_pkg::CTRL_BPP_LSB +: 3]);
   always_comb begin
      shifted = fifo_word;
      last_pos = 5'h00;
      pix = 8'h00;
      unique case (bpp)
         vpc_pkg::BPP1: begin
            shifted = fifo_word >> pix_pos_reg;
            last_pos = 5'h1f;
            pix = {7'h00, shifted[0]};
         end
         vpc_pkg::BPP2: begin
            shifted = fifo_word >> {pix_pos_reg[3:0], 1'b0};
            last_pos = 5'h0f;
            pix = {6'h00, shifted[1:0]};
         end
         vpc_pkg::BPP4: begin
            shifted = fifo_word >> {pix_pos_reg[2:0], 2'h0};
            last_pos = 5'h07;
            pix = {4'h0, shifted[3:0]};
         end
         vpc_pkg::BPP8, vpc_pkg::BPP16: begin
            shifted = fifo_word >> {pix_pos_reg[1:0], 3'h0};
            last_pos = 5'h03;
            pix = shifted[7:0];
         end
         vpc_pkg::BPP32: begin
            last_pos = 5'h00;
            pix = fifo_word[7:0];
         end
         default: ;
      endcase
   end
   always_comb begin
      idx_r = pix;
      idx_g = pix;
      idx_b = pix;
      idx_e = pix[3:0];
      if (bpp == vpc_pkg::BPP8 || bpp == vpc_pkg::BPP16) begin
         idx_e = (pix[7:4] == 4'h0) ? pix[3:0] : 4'h0;
      end else if (bpp == vpc_pkg::BPP32) begin
         idx_r = fifo_word[7:0];
         idx_g = fifo_word[15:8];
         idx_b = fifo_word[23:16];
         idx_e = fifo_word[27:24];
      end
   end
   assign fifo_pop = pixel_clock_tick && fifo_valid && pix_pos_reg >= last_pos;

   logic pal_mode_port;
   assign pal_mode_port = !video_control_register[vpc_pkg::CTRL_HIRES_BIT] &&
      !video_control_register[vpc_pkg::CTRL_LCD_BIT];
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pix_pos_reg <= 5'h00;
         dac_red <= 8'h00;
         dac_green <= 8'h00;
         dac_blue <= 8'h00;
         pixel_out_valid <= 1'b0;
         extension_output_port <= 8'h00;
      end else begin
         extension_output_port[7:4] <= ext_reg[7:4];
         if (!pal_mode_port) begin
            extension_output_port[3:0] <= ext_reg[3:0];
         end
         pixel_out_valid <= pixel_clock_tick && fifo_valid;
         if (flyback) begin
            pix_pos_reg <= 5'h00;
         end else if (pixel_clock_tick && fifo_valid) begin
            pix_pos_reg <= fifo_pop ? 5'h00 : pix_pos_reg + 5'h01;
            dac_red <= red_lut[idx_r];
            dac_green <= green_lut[idx_g];
            dac_blue <= blue_lut[idx_b];
            if (pal_mode_port) begin
               extension_output_port[3:0] <= ext_lut[idx_e];
            end
         end
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_read) begin
         unique case (reg_addr)
            vpc_pkg::ADDR_CTRL: reg_rdata <= video_control_register;
            vpc_pkg::ADDR_SYNTH: reg_rdata <= synth_reg;
            vpc_pkg::ADDR_EXT: reg_rdata <= {24'h000000, ext_reg};
            vpc_pkg::ADDR_PAL_INDEX: reg_rdata <= {24'h000000, pal_index_reg};
            vpc_pkg::ADDR_PAL_DATA: reg_rdata <= {4'h0,
               (pal_index_reg[7:4] == 4'h0) ? ext_lut[pal_index_reg[3:0]] : 4'h0,
               blue_lut[pal_index_reg], green_lut[pal_index_reg], red_lut[pal_index_reg]};
            vpc_pkg::ADDR_STATUS: reg_rdata <= {16'h0000, 8'(fifo_level), 4'h0,
               video_dma_request, fifo_valid, down_reg, up_reg};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// [vpc_top_note_unused.sv]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [vpc_pixel_path_props.sv]
`timescale 1ns/10ps
`default_nettype none
module vpc_pixel_path_props #(
   parameter int VFIFO_DEPTH = 32
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic vco_clock_in,
   input wire logic vco_clock_inverted_out,
   input wire logic phase_compare_oe,
   input wire logic phase_compare_mid,
   input wire logic pixel_clock_tick,
   input wire logic flyback,
   input wire logic video_word_ready,
   input wire logic video_dma_request,
   input wire logic pixel_out_valid,
   input wire logic [7:0] extension_output_port
);
   logic [31:0] ctrl_q;
   // Shadow of the control register, seen from the register port
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= vpc_pkg::CTRL_RESET;
      end else if (reg_write && reg_addr == vpc_pkg::ADDR_CTRL) begin
         ctrl_q <= reg_wdata;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside read answer");
   vco_inverse_a: assert property ($past(reset_n) |-> vco_clock_inverted_out == !$past(vco_clock_in))
      else $error("inverted vco output wrong");
   mid_driven_a: assert property (phase_compare_mid |-> phase_compare_oe)
      else $error("midpoint pulse without drive");
   mid_short_a: assert property (phase_compare_mid |=> !phase_compare_mid)
      else $error("midpoint drive longer than one cycle");
   no_source_a: assert property ($past(ctrl_q[4:3], 2) == 2'h3 &&
      $past(ctrl_q[4:3]) == 2'h3 |-> !pixel_clock_tick)
      else $error("pixel tick with no source selected");
   pixel_tick_a: assert property (pixel_out_valid |-> $past(pixel_clock_tick))
      else $error("pixel shown without pixel tick");
   flyback_req_a: assert property ($past(flyback) |-> !video_dma_request)
      else $error("request during flyback");
   zero_preload_a: assert property ($past(ctrl_q[10:8]) == 3'h0 |-> !video_dma_request)
      else $error("request with preload zero");
   flush_ready_a: assert property ($past(reset_n, 2) && $past(flyback, 2) &&
      $past(flyback) |-> video_word_ready)
      else $error("fifo not ready after flush");
   ext_high_a: assert property (reg_write && reg_addr == vpc_pkg::ADDR_EXT
      |-> ##2 extension_output_port[7:4] == $past(reg_wdata[7:4], 2))
      else $error("extension high lines not following register");
   cover property (phase_compare_oe);
   cover property ($rose(video_dma_request));
   cover property (pixel_out_valid);
   cover property (!video_word_ready);
   cover property (phase_compare_mid);
endmodule
bind vpc_pixel_path vpc_pixel_path_props #(.VFIFO_DEPTH(VFIFO_DEPTH)) props_u (.clk(clk),
   .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_rdata(reg_rdata), .vco_clock_in(vco_clock_in),
   .vco_clock_inverted_out(vco_clock_inverted_out), .phase_compare_oe(phase_compare_oe),
   .phase_compare_mid(phase_compare_mid), .pixel_clock_tick(pixel_clock_tick),
   .flyback(flyback), .video_word_ready(video_word_ready),
   .video_dma_request(video_dma_request), .pixel_out_valid(pixel_out_valid),
   .extension_output_port(extension_output_port));
`default_nettype wire

// [vpc_vco_model.sv]
`timescale 1ns/10ps
`default_nettype none
module vpc_vco_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic phase_compare_out,
   input wire logic phase_compare_oe,
   input wire logic phase_compare_mid,
   output logic vco_clock_in
);
   logic [3:0] half_reg;
   logic [3:0] cnt_reg;
   logic oe_reg;
   // Loop filter: one step per drive burst, high speeds the oscillator up
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         half_reg <= 4'h5;
         oe_reg <= 1'b0;
      end else begin
         oe_reg <= phase_compare_oe;
         if (phase_compare_oe && !oe_reg && !phase_compare_mid) begin
            if (phase_compare_out && half_reg > 4'h1) begin
               half_reg <= half_reg - 4'h1;
            end else if (!phase_compare_out && half_reg < 4'h8) begin
               half_reg <= half_reg + 4'h1;
            end
         end
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg <= 4'h0;
         vco_clock_in <= 1'b0;
      end else if (cnt_reg + 4'h1 >= half_reg) begin
         cnt_reg <= 4'h0;
         vco_clock_in <= !vco_clock_in;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
   logic video_word_valid = 1'b0, flyback = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, video_word_data = 32'h0, reg_rdata, v;
   logic [7:0] cyc_reg = 8'h0, dac_red, dac_green, dac_blue, extension_output_port;
   logic vco_clock_in, phase_compare_out, phase_compare_oe, phase_compare_mid;
   logic pixel_clock_tick, video_word_ready, video_dma_request, pixel_out_valid;
   logic [27:0] pix_q[$];
   logic [27:0] exp_pix [5] = '{28'h3312111, 28'h7615141, 28'h7302010, 28'h3312111, 28'h3612011};
   logic [4:0] clk_sel [4] = '{5'h10, 5'h12, 5'h08, 5'h0f};
   int tick_exp [4] = '{24, 8, 48, 6};
   int errors = 0, total_checks = 0, ticks = 0;
   vpc_pixel_path #(.VFIFO_DEPTH(8)) dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .io_reference_clock(cyc_reg[1]), .vco_clock_in(vco_clock_in),
      .high_freq_clock_in(cyc_reg[0]), .vco_clock_inverted_out(),
      .phase_compare_out(phase_compare_out), .phase_compare_oe(phase_compare_oe),
      .phase_compare_mid(phase_compare_mid), .pixel_clock_tick(pixel_clock_tick),
      .video_word_data(video_word_data), .video_word_valid(video_word_valid),
      .video_word_ready(video_word_ready), .flyback(flyback),
      .video_dma_request(video_dma_request), .dac_red(dac_red), .dac_green(dac_green),
      .dac_blue(dac_blue), .pixel_out_valid(pixel_out_valid),
      .extension_output_port(extension_output_port));
   vpc_vco_model vco_u (.clk(clk), .reset_n(reset_n), .phase_compare_out(phase_compare_out),
      .phase_compare_oe(phase_compare_oe), .phase_compare_mid(phase_compare_mid),
      .vco_clock_in(vco_clock_in));
   initial begin
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc_reg <= cyc_reg + 8'h1;
      if (pixel_out_valid === 1'b1) pix_q.push_back({extension_output_port[3:0], dac_blue,
         dac_green, dac_red});
      if (pixel_clock_tick === 1'b1) ticks++;
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic push(input logic [31:0] w);
      int i = 0;
      @(posedge clk);
      video_word_valid <= 1'b1;
      video_word_data <= w;
      do begin
         @(posedge clk);
         i++;
      end while (video_word_ready !== 1'b1 && i < 50);
      video_word_valid <= 1'b0;
   endtask
   task automatic count_ticks(input int n);
      @(negedge clk);
      ticks = 0;
      repeat (n) @(negedge clk);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("watchdog expired");
      close_out;
   end
   initial begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      rd(vpc_pkg::ADDR_CTRL, v);
      chk("ctrl reset", vpc_pkg::CTRL_RESET, v);
      rd(vpc_pkg::ADDR_SYNTH, v);
      chk("synth reset", vpc_pkg::SYNTH_RESET, v);
      wr(4'h9, 32'hffff_ffff);
      rd(4'h9, v);
      chk("unmapped", 32'h0, v);
      wr(vpc_pkg::ADDR_SYNTH, 32'h0000_3f01);
      rd(vpc_pkg::ADDR_SYNTH, v);
      chk("synth moduli", 32'h0000_3f01, v);
      wr(vpc_pkg::ADDR_EXT, 32'h0000_00a5);
      wr(vpc_pkg::ADDR_CTRL, 32'h0001_0018);
      repeat (3) @(posedge clk);
      chk("ext high", 32'ha, {28'h0, extension_output_port[7:4]});
      chk("ext low hires", 32'h5, {28'h0, extension_output_port[3:0]});
      $display("test registers done");
      for (int k = 0; k < 4; k++) begin
         wr(vpc_pkg::ADDR_CTRL, {27'h0, clk_sel[k]});
         repeat (4) @(posedge clk);
         count_ticks(96);
         chk("tick count", tick_exp[k], ticks);
      end
      wr(vpc_pkg::ADDR_SYNTH, vpc_pkg::SYNTH_RESET);
      wr(vpc_pkg::ADDR_CTRL, 32'h0000_0000);
      repeat (600) @(posedge clk);
      count_ticks(96);
      chk("vco lock rate", 1, 32'(ticks >= 12 && ticks <= 36));
      $display("test clocks done");
      wr(vpc_pkg::ADDR_CTRL, 32'h0000_3118);
      repeat (3) @(posedge clk);
      chk("request in flyback", 0, video_dma_request);
      flyback <= 1'b0;
      repeat (3) @(posedge clk);
      chk("request empty", 1, video_dma_request);
      repeat (3) push(32'h0);
      repeat (3) @(posedge clk);
      chk("request below 4n", 1, video_dma_request);
      push(32'h0);
      repeat (3) @(posedge clk);
      chk("request at 4n", 0, video_dma_request);
      repeat (4) push(32'h0);
      repeat (3) @(posedge clk);
      chk("ready when full", 0, video_word_ready);
      rd(vpc_pkg::ADDR_STATUS, v);
      chk("level full", 32'h8, {24'h0, v[15:8]});
      flyback <= 1'b1;
      repeat (3) @(posedge clk);
      flyback <= 1'b0;
      rd(vpc_pkg::ADDR_STATUS, v);
      chk("level flushed", 32'h0, {24'h0, v[15:8]});
      $display("test fifo done");
      wr(vpc_pkg::ADDR_PAL_INDEX, 32'h0);
      wr(vpc_pkg::ADDR_PAL_DATA, 32'h0730_2010);
      wr(vpc_pkg::ADDR_PAL_DATA, 32'h0331_2111);
      wr(vpc_pkg::ADDR_PAL_INDEX, 32'h11);
      wr(vpc_pkg::ADDR_PAL_DATA, 32'h0961_5141);
      wr(vpc_pkg::ADDR_PAL_INDEX, 32'h1);
      rd(vpc_pkg::ADDR_PAL_DATA, v);
      chk("palette entry", 32'h0331_2111, v);
      pix_q.delete();
      push(32'h0100_1101);
      wr(vpc_pkg::ADDR_CTRL, 32'h0000_3110);
      repeat (40) @(posedge clk);
      wr(vpc_pkg::ADDR_CTRL, 32'h0000_5118);
      push(32'hf111_0001);
      wr(vpc_pkg::ADDR_CTRL, 32'h0000_5110);
      repeat (20) @(posedge clk);
      wr(vpc_pkg::ADDR_CTRL, 32'h0000_5118);
      chk("pixel count", 5, pix_q.size());
      for (int i = 0; i < 5 && i < pix_q.size(); i++) begin
         chk("pixel colour", {4'h0, exp_pix[i]}, {4'h0, pix_q[i]});
      end
      $display("test palette done");
      close_out;
   end
endmodule
`default_nettype wire
